// *** hw/hmdp_pkg.sv ***
package hmdp_pkg;

  // ----------------------------------------------------------------
  // widths of the port and of the memories behind it
  // ----------------------------------------------------------------
  localparam int DATA_W  = 16;
  localparam int PM_W    = 24;
  localparam int ADDR_W  = 14;
  localparam int OVL_W   = 8;
  localparam int PM_LO_W = PM_W - DATA_W;

  // ----------------------------------------------------------------
  // device registers, core data memory offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 14'h3FE0;  // host_port_address_control
  localparam logic [ADDR_W-1:0] OVL_OFFSET  = 14'h3FE7;  // host_port_overlay_config
  localparam logic [ADDR_W-1:0] CTRL_REGION = 14'h3FE0;  // first memory-mapped control word
  localparam logic [ADDR_W-1:0] BOOT_VECTOR = 14'h0000;
  localparam int CW_OVL_BIT     = 15;                    // control word: overlay select
  localparam int CW_DEST_BIT    = 14;                    // control word: 1 = program memory
  localparam int SHORT_READ_BIT = 14;                    // overlay register bit
  localparam logic [2:0] BOOT_HOST_PORT = 3'h5;          // {mode c, mode b, mode a}
  localparam logic [3:0] STRB_IDLE = 4'hD;               // {write_n, read_n, latch, select_n}

  // ----------------------------------------------------------------
  // host timing
  // ----------------------------------------------------------------
  localparam int T_CLK_NS    = 40;
  localparam int T_LATCH_NS  = 10;
  localparam int T_AHOLD_NS  = 3;
  localparam int LATCH_CYC_R = (T_LATCH_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int AHOLD_CYC_R = (T_AHOLD_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam logic [3:0] LATCH_CYC = 4'(LATCH_CYC_R < 1 ? 1 : LATCH_CYC_R);
  localparam logic [3:0] AHOLD_CYC = 4'(AHOLD_CYC_R < 1 ? 1 : AHOLD_CYC_R);
  localparam logic [3:0] GAP_CYC   = 4'h4;               // lets the device see the release

  // ----------------------------------------------------------------
  // host controller apb map
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CMD    = 12'h000;
  localparam logic [11:0] APB_WDATA  = 12'h004;
  localparam logic [11:0] APB_RDATA  = 12'h008;
  localparam logic [11:0] APB_STATUS = 12'h00C;

  typedef enum logic [1:0] {OP_LATCH, OP_WRITE, OP_READ, OP_NONE} hmdp_op_type;

endpackage

// *** hw/hmdp_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface hmdp_if;
  logic              port_select_n;
  logic              addr_latch_strobe;
  logic              port_read_n;
  logic              port_write_n;
  logic              access_ack_n;
  logic [15:0]       host_bus_out;
  logic              host_bus_oe;
  logic [15:0]       dev_bus_out;
  logic              dev_bus_oe;
  logic [15:0]       mux_addr_data_bus;

  // wire level of the shared bus; an undriven bus reads as zero
  assign mux_addr_data_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 16'h0000);

  modport dev (input port_select_n, addr_latch_strobe, port_read_n, port_write_n,
               mux_addr_data_bus, output access_ack_n, dev_bus_out, dev_bus_oe);
  modport host (output port_select_n, addr_latch_strobe, port_read_n, port_write_n,
                host_bus_out, host_bus_oe, input access_ack_n, mux_addr_data_bus);
endinterface
`default_nettype wire

// *** hw/hmdp_dev.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmdp_dev (
  input  wire logic                         I_CLK,
  input  wire logic                         I_NRST,
  hmdp_if.dev                               LINK,
  input  wire logic [2:0]                   I_BOOT_MODE,
  input  wire logic                         I_CORE_WE,
  input  wire logic [hmdp_pkg::ADDR_W-1:0]  I_CORE_ADDR,
  input  wire logic [hmdp_pkg::DATA_W-1:0]  I_CORE_WDATA,
  output      logic [hmdp_pkg::DATA_W-1:0]  O_OVERLAY_CONFIG,
  output      logic                         O_CORE_HOLD,
  output      logic                         O_MEM_REQ,
  output      logic                         O_MEM_WE,
  output      logic                         O_MEM_PM,
  output      logic [hmdp_pkg::ADDR_W-1:0]  O_MEM_ADDR,
  output      logic [hmdp_pkg::OVL_W-1:0]   O_MEM_OVL,
  output      logic [hmdp_pkg::PM_W-1:0]    O_MEM_WDATA,
  input  wire logic [hmdp_pkg::PM_W-1:0]    I_MEM_RDATA
);
  import hmdp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_ACCESS, ST_DONE} hmdp_dstate_type;

  typedef struct packed {
    hmdp_dstate_type   state;
    logic [3:0]        strb_s1;    // first synchroniser stage
    logic [3:0]        strb_s2;
    logic [3:0]        strb_s3;    // one older, for edge detection
    logic [DATA_W-1:0] bus_s1;
    logic [DATA_W-1:0] bus_s2;
    logic [ADDR_W-1:0] addr;
    logic              dest_pm;
    logic [OVL_W-1:0]  ovl;
    logic              short_rd;
    logic              hi_half;    // first half of a program word is done
    logic [DATA_W-1:0] hold_hi;
    logic [PM_W-1:0]   rd_buf;
    logic              is_read;
    logic              ack_n;
    logic [DATA_W-1:0] bus_out;
    logic              bus_oe;
    logic              mem_req;
    logic              mem_we;
    logic [PM_W-1:0]   mem_wdata;
    logic              boot_cap;
    logic              core_hold;
  } hmdp_dev_reg_type;

  hmdp_dev_reg_type r_reg;
  hmdp_dev_reg_type r_next;

  logic sel_act;
  logic rd_act;
  logic wr_act;
  logic latch_end;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // apply a control word from either the host latch or the core
  function automatic hmdp_dev_reg_type apply_ctrl(input hmdp_dev_reg_type s,
                                                  input logic [DATA_W-1:0] w);
    hmdp_dev_reg_type t;
    t = s;
    if (w[CW_OVL_BIT]) begin
      t.ovl = w[OVL_W-1:0];
    end else begin
      t.addr    = w[ADDR_W-1:0];
      t.dest_pm = w[CW_DEST_BIT];
      t.hi_half = 1'b0;
    end
    return t;
  endfunction

  // the 16-bit slice of the read buffer that the host sees next
  function automatic logic [DATA_W-1:0] read_slice(input hmdp_dev_reg_type s);
    logic [DATA_W-1:0] v;
    v = s.rd_buf[DATA_W-1:0];
    if (s.dest_pm && s.hi_half) begin
      v = {{DATA_W-PM_LO_W{1'b0}}, s.rd_buf[PM_LO_W-1:0]};
    end else if (s.dest_pm) begin
      v = s.rd_buf[PM_W-1:PM_LO_W];
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // strobe decode, taken from the second synchroniser stage
  // ----------------------------------------------------------------
  assign sel_act   = !r_reg.strb_s2[0];
  assign rd_act    = !r_reg.strb_s2[2];
  assign wr_act    = !r_reg.strb_s2[3];
  // latch strobe falls under select, or select lifts while latch is high
  assign latch_end = (sel_act && r_reg.strb_s3[1] && !r_reg.strb_s2[1]) ||
                     (!r_reg.strb_s3[0] && r_reg.strb_s2[0] && r_reg.strb_s2[1]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next         = r_reg;
    // pins carry no timing relation to the clock, so resample everything
    r_next.strb_s1 = {LINK.port_write_n, LINK.port_read_n,
                      LINK.addr_latch_strobe, LINK.port_select_n};
    r_next.strb_s2 = r_reg.strb_s1;
    r_next.strb_s3 = r_reg.strb_s2;
    r_next.bus_s1  = LINK.mux_addr_data_bus;
    r_next.bus_s2  = r_reg.bus_s1;
    r_next.mem_req = 1'b0;
    r_next.mem_we  = 1'b0;

    // boot straps are caught on the first edge after reset release
    if (!r_reg.boot_cap) begin
      r_next.boot_cap  = 1'b1;
      r_next.core_hold = (I_BOOT_MODE == BOOT_HOST_PORT);
    end

    // core side register writes; host latch below wins on a tie
    if (I_CORE_WE && I_CORE_ADDR == CTRL_OFFSET) begin
      r_next = apply_ctrl(r_next, I_CORE_WDATA);
    end else if (I_CORE_WE && I_CORE_ADDR == OVL_OFFSET) begin
      r_next.ovl      = I_CORE_WDATA[OVL_W-1:0];
      r_next.short_rd = I_CORE_WDATA[SHORT_READ_BIT];
    end

    case (r_reg.state)
      ST_IDLE: begin
        if (latch_end) begin
          r_next = apply_ctrl(r_next, r_reg.bus_s2);
        end else if (sel_act && (rd_act || wr_act)) begin
          r_next.ack_n   = 1'b1;
          r_next.is_read = rd_act;
          r_next.state   = ST_SYNC;
        end
      end
      ST_SYNC: begin
        r_next.state = ST_ACCESS;
        if (r_reg.is_read) begin
          r_next.mem_req = !(r_reg.dest_pm && r_reg.hi_half);
          // short-read mode hands back the previous word at once
          if (r_reg.short_rd) begin
            r_next.bus_out = read_slice(r_reg);
            r_next.bus_oe  = 1'b1;
          end
        end else if (r_reg.dest_pm && !r_reg.hi_half) begin
          r_next.hold_hi = r_reg.bus_s2;
        end else if (!r_reg.dest_pm && r_reg.addr >= CTRL_REGION) begin
          // control space is shielded; only the short-read bit may change
          if (r_reg.addr == OVL_OFFSET) begin
            r_next.short_rd = r_reg.bus_s2[SHORT_READ_BIT];
          end
        end else begin
          r_next.mem_req   = 1'b1;
          r_next.mem_we    = 1'b1;
          r_next.mem_wdata = r_reg.dest_pm ? {r_reg.hold_hi, r_reg.bus_s2[PM_LO_W-1:0]}
                                           : {{PM_LO_W{1'b0}}, r_reg.bus_s2};
        end
      end
      ST_ACCESS: begin
        // memory answers combinationally in the request cycle
        if (r_reg.mem_req && !r_reg.mem_we) begin
          r_next.rd_buf = r_reg.dest_pm ? I_MEM_RDATA
                                        : {{PM_LO_W{1'b0}}, I_MEM_RDATA[DATA_W-1:0]};
        end
        if (r_reg.is_read && !r_reg.short_rd) begin
          r_next.bus_out = read_slice(r_next);
          r_next.bus_oe  = 1'b1;
        end
        if (r_reg.mem_we && r_reg.dest_pm && r_reg.addr == BOOT_VECTOR) begin
          r_next.core_hold = 1'b0;
        end
        if (r_reg.dest_pm && !r_reg.hi_half) begin
          r_next.hi_half = 1'b1;
        end else begin
          r_next.hi_half = 1'b0;
          r_next.addr    = r_reg.addr + 1'b1;
        end
        r_next.ack_n = 1'b0;
        r_next.state = ST_DONE;
      end
      ST_DONE: begin
        if (!sel_act || (!rd_act && !wr_act)) begin
          r_next.bus_oe = 1'b0;
          r_next.state  = ST_IDLE;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase

    if (!I_NRST) begin
      r_next         = '0;
      r_next.strb_s1 = STRB_IDLE;
      r_next.strb_s2 = STRB_IDLE;
      r_next.strb_s3 = STRB_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs; the latched address goes only to memory, never the bus
  // ----------------------------------------------------------------
  assign LINK.access_ack_n = r_reg.ack_n;
  assign LINK.dev_bus_out  = r_reg.bus_out;
  assign LINK.dev_bus_oe   = r_reg.bus_oe;
  assign O_OVERLAY_CONFIG  = {1'b0, r_reg.short_rd, {DATA_W-OVL_W-2{1'b0}}, r_reg.ovl};
  assign O_CORE_HOLD       = r_reg.core_hold;
  assign O_MEM_REQ         = r_reg.mem_req;
  assign O_MEM_WE          = r_reg.mem_we;
  assign O_MEM_PM          = r_reg.dest_pm;
  assign O_MEM_ADDR        = r_reg.addr;
  assign O_MEM_OVL         = r_reg.ovl;
  assign O_MEM_WDATA       = r_reg.mem_wdata;

endmodule
`default_nettype wire

// *** hw/hmdp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmdp_host (
  input  wire logic         I_CLK,
  input  wire logic         I_NRST,
  hmdp_if.host              LINK,
  input  wire logic         I_PSEL,
  input  wire logic         I_PENABLE,
  input  wire logic         I_PWRITE,
  input  wire logic [11:0]  I_PADDR,
  input  wire logic [31:0]  I_PWDATA,
  output      logic [31:0]  O_PRDATA,
  output      logic         O_PREADY,
  output      logic         O_PSLVERR
);
  import hmdp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE, H_CHECK, H_LATCH, H_HOLD, H_WAIT_BUSY, H_WAIT_DONE, H_GAP
  } hmdp_hstate_type;

  typedef struct packed {
    hmdp_hstate_type   state;
    hmdp_op_type       op;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              busy;
    logic              done;
    logic [3:0]        cnt;
    logic              sel_n;
    logic              latch;
    logic              rd_n;
    logic              wr_n;
    logic [DATA_W-1:0] bus_out;
    logic              bus_oe;
    logic [31:0]       prdata;
  } hmdp_host_reg_type;

  hmdp_host_reg_type r_reg;
  hmdp_host_reg_type r_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;

    // apb: read data is prepared in the setup cycle, zero waits
    if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      if (I_PADDR == APB_RDATA) begin
        r_next.prdata = {16'h0000, r_reg.rdata};
      end else if (I_PADDR == APB_STATUS) begin
        r_next.prdata = {30'h0, r_reg.done, r_reg.busy};
      end else begin
        r_next.prdata = 32'h00000000;
      end
    end
    if (I_PSEL && I_PENABLE && I_PWRITE) begin
      if (I_PADDR == APB_WDATA) begin
        r_next.wdata = I_PWDATA[DATA_W-1:0];
      end else if (I_PADDR == APB_CMD && !r_reg.busy) begin
        // commands while busy are dropped
        r_next.op    = hmdp_op_type'(I_PWDATA[1:0]);
        r_next.busy  = 1'b1;
        r_next.done  = 1'b0;
        r_next.state = H_CHECK;
      end
    end

    case (r_reg.state)
      H_IDLE: ;
      H_CHECK: begin
        if (!LINK.access_ack_n) begin
          r_next.sel_n = 1'b0;
          if (r_reg.op == OP_LATCH) begin
            // overlay words go out with bits 14:8 forced to zero
            r_next.bus_out = r_reg.wdata[CW_OVL_BIT] ?
                             {1'b1, {DATA_W-OVL_W-1{1'b0}}, r_reg.wdata[OVL_W-1:0]} :
                             r_reg.wdata;
            r_next.bus_oe  = 1'b1;
            r_next.latch   = 1'b1;
            r_next.cnt     = LATCH_CYC;
            r_next.state   = H_LATCH;
          end else if (r_reg.op == OP_WRITE) begin
            r_next.bus_out = r_reg.wdata;
            r_next.bus_oe  = 1'b1;
            r_next.wr_n    = 1'b0;
            r_next.state   = H_WAIT_BUSY;
          end else if (r_reg.op == OP_READ) begin
            r_next.rd_n  = 1'b0;
            r_next.state = H_WAIT_BUSY;
          end else begin
            r_next.sel_n = 1'b1;
            r_next.cnt   = GAP_CYC;
            r_next.state = H_GAP;
          end
        end
      end
      H_LATCH: begin
        r_next.cnt = r_reg.cnt - 1'b1;
        if (r_reg.cnt == 4'h1) begin
          r_next.latch = 1'b0;                           // falling edge stores the word
          r_next.cnt   = AHOLD_CYC;
          r_next.state = H_HOLD;
        end
      end
      H_HOLD: begin
        r_next.cnt = r_reg.cnt - 1'b1;
        if (r_reg.cnt == 4'h1) begin
          r_next.sel_n  = 1'b1;
          r_next.bus_oe = 1'b0;
          r_next.cnt    = GAP_CYC;
          r_next.state  = H_GAP;
        end
      end
      H_WAIT_BUSY: begin
        if (LINK.access_ack_n) begin
          r_next.state = H_WAIT_DONE;
        end
      end
      H_WAIT_DONE: begin
        if (!LINK.access_ack_n) begin
          if (!r_reg.rd_n) begin
            r_next.rdata = LINK.mux_addr_data_bus;
          end
          r_next.sel_n  = 1'b1;
          r_next.rd_n   = 1'b1;
          r_next.wr_n   = 1'b1;
          r_next.bus_oe = 1'b0;
          r_next.cnt    = GAP_CYC;
          r_next.state  = H_GAP;
        end
      end
      H_GAP: begin
        // the device sees the release two edges late; keep the bus quiet
        r_next.cnt = r_reg.cnt - 1'b1;
        if (r_reg.cnt == 4'h1) begin
          r_next.busy  = 1'b0;
          r_next.done  = 1'b1;
          r_next.state = H_IDLE;
        end
      end
      default: r_next.state = H_IDLE;
    endcase

    if (!I_NRST) begin
      r_next       = '0;
      r_next.sel_n = 1'b1;
      r_next.rd_n  = 1'b1;
      r_next.wr_n  = 1'b1;
      r_next.op    = OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    r_reg <= r_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign LINK.port_select_n     = r_reg.sel_n;
  assign LINK.addr_latch_strobe = r_reg.latch;
  assign LINK.port_read_n       = r_reg.rd_n;
  assign LINK.port_write_n      = r_reg.wr_n;
  assign LINK.host_bus_out      = r_reg.bus_out;
  assign LINK.host_bus_oe       = r_reg.bus_oe;
  assign O_PRDATA               = r_reg.prdata;
  assign O_PREADY               = 1'b1;
  assign O_PSLVERR              = 1'b0;

endmodule
`default_nettype wire

// *** tb/hmdp_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module hmdp_props (
  input wire logic        I_CLK,
  input wire logic        I_NRST,
  input wire logic        port_select_n,
  input wire logic        addr_latch_strobe,
  input wire logic        port_read_n,
  input wire logic        port_write_n,
  input wire logic        access_ack_n,
  input wire logic        host_bus_oe,
  input wire logic        dev_bus_oe,
  input wire logic [15:0] mux_addr_data_bus
);
  // --------
  // a data strobe is select plus read or write
  // --------
  wire strb = !port_select_n && !(port_read_n && port_write_n);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  sequence s_start;
    $rose(strb);
  endsequence
  // busy window: ack rises, then falls again within the access time
  sequence s_turn;
    access_ack_n ##[1:2] !access_ack_n;
  endsequence
  ack_turn_a: assert property (s_start |-> ##[1:4] s_turn)
    else $error("ack did not go busy and back after a strobe");
  ack_bound_a: assert property ($rose(access_ack_n) |-> ##[1:2] !access_ack_n)
    else $error("ack stayed busy too long");
  host_wait_a: assert property (s_start |-> !access_ack_n)
    else $error("strobe started while busy");
  host_hold_a: assert property (strb && access_ack_n |=> strb)
    else $error("strobe released before ack");
  strobe_gap_a: assert property ($fell(strb) |-> !strb [*4])
    else $error("strobes too close");
  latch_ready_a: assert property ($rose(addr_latch_strobe) |-> !access_ack_n && !port_select_n)
    else $error("latch started while busy or unselected");
  latch_hold_a: assert property ($fell(addr_latch_strobe) |-> host_bus_oe && $stable(mux_addr_data_bus))
    else $error("address not held at latch end");
  read_data_a: assert property ($fell(access_ack_n) && !port_read_n |-> dev_bus_oe)
    else $error("read data missing at ack");
  write_quiet_a: assert property (!port_write_n || addr_latch_strobe |-> !dev_bus_oe)
    else $error("device drove bus outside a read");
  one_driver_a: assert property (!(host_bus_oe && dev_bus_oe))
    else $error("bus contention");
  oe_cause_a: assert property (dev_bus_oe |-> !$past(port_read_n, 1) || !$past(port_read_n, 2)
    || !$past(port_read_n, 3) || !$past(port_read_n, 4))
    else $error("device drove bus with no read");
endmodule
`default_nettype wire

// *** tb/tb_host_memory_dma_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_host_memory_dma_port;
  import hmdp_pkg::*;
  typedef struct packed {
    hmdp_op_type op;
    logic [15:0] w;
    logic [15:0] exp;
    logic [15:0] msk;
  } hmdp_row_type;
  // --------
  // pm words 0 and 1 as two halves each, then dm block, then read back
  // --------
  localparam hmdp_row_type ROWS [0:15] = '{
    '{OP_LATCH, 16'h4000, 16'h0000, 16'h0000}, '{OP_WRITE, 16'h1234, 16'h0000, 16'h0000},
    '{OP_WRITE, 16'h0056, 16'h0000, 16'h0000}, '{OP_WRITE, 16'hABCD, 16'h0000, 16'h0000},
    '{OP_WRITE, 16'h00EF, 16'h0000, 16'h0000}, '{OP_LATCH, 16'h0010, 16'h0000, 16'h0000},
    '{OP_WRITE, 16'hA1A1, 16'h0000, 16'h0000}, '{OP_WRITE, 16'hB2B2, 16'h0000, 16'h0000},
    '{OP_LATCH, 16'h0010, 16'h0000, 16'h0000}, '{OP_READ, 16'h0000, 16'hA1A1, 16'hFFFF},
    '{OP_READ, 16'h0000, 16'hB2B2, 16'hFFFF}, '{OP_LATCH, 16'h4000, 16'h0000, 16'h0000},
    '{OP_READ, 16'h0000, 16'h1234, 16'hFFFF}, '{OP_READ, 16'h0000, 16'h0056, 16'h00FF},
    '{OP_READ, 16'h0000, 16'hABCD, 16'hFFFF}, '{OP_READ, 16'h0000, 16'h00EF, 16'h00FF}};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  boot_mode = BOOT_HOST_PORT;
  logic        core_we = 1'b0;
  logic [13:0] core_addr = 14'h0000;
  logic [15:0] core_wdata = 16'h0000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic [15:0] ovl_cfg;
  logic        hold;
  logic        mreq;
  logic        mwe;
  logic        mpm;
  logic [13:0] maddr;
  logic [23:0] mwdata;
  logic [7:0]  movl;
  logic [23:0] pm [0:63];
  logic [15:0] dm [0:63];
  logic [31:0] q;
  logic [15:0] r;
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  int          ctl_hits = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  hmdp_if link();
  hmdp_host hmdp_host_inst (.I_CLK(clk), .I_NRST(nrst), .LINK(link), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR());
  hmdp_dev hmdp_dev_inst (.I_CLK(clk), .I_NRST(nrst), .LINK(link), .I_BOOT_MODE(boot_mode),
    .I_CORE_WE(core_we), .I_CORE_ADDR(core_addr), .I_CORE_WDATA(core_wdata),
    .O_OVERLAY_CONFIG(ovl_cfg), .O_CORE_HOLD(hold), .O_MEM_REQ(mreq), .O_MEM_WE(mwe),
    .O_MEM_PM(mpm), .O_MEM_ADDR(maddr), .O_MEM_OVL(movl), .O_MEM_WDATA(mwdata),
    .I_MEM_RDATA(mpm ? pm[maddr[5:0]] : {8'h00, dm[maddr[5:0]]}));
  hmdp_props hmdp_props_inst (.I_CLK(clk), .I_NRST(nrst), .port_select_n(link.port_select_n),
    .addr_latch_strobe(link.addr_latch_strobe), .port_read_n(link.port_read_n),
    .port_write_n(link.port_write_n), .access_ack_n(link.access_ack_n),
    .host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe),
    .mux_addr_data_bus(link.mux_addr_data_bus));
  // memory model; only 64 words are kept, so control-space hits are counted apart
  always @(posedge clk) begin
    if (mreq && mwe) begin
      if (mpm) pm[maddr[5:0]] <= mwdata;
      else dm[maddr[5:0]] <= mwdata[15:0];
      if (!mpm && maddr >= CTRL_REGION) ctl_hits <= ctl_hits + 1;
    end
  end
  // hang guard, far above the several hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one port operation through the controller, polling done
  task automatic do_op(input hmdp_op_type op, input logic [15:0] w);
    int n = 0;
    apb(1'b1, APB_WDATA, {16'h0000, w});
    apb(1'b1, APB_CMD, {30'h0, op});
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 200) begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end
    chk("op done", 32'(q[1]), 32'h1);
    apb(1'b0, APB_RDATA, 32'h0);
    r = q[15:0];
  endtask
  task automatic core_wr(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    core_we <= 1'b1;
    core_addr <= a;
    core_wdata <= d;
    @(posedge clk);
    core_we <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] m);
    @(posedge clk);
    nrst <= 1'b0;
    boot_mode <= m;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // --------
  // main sequence
  // --------
  initial begin
    do_reset(BOOT_HOST_PORT);
    chk("boot hold", 32'(hold), 32'h1);
    chk("reset overlay", 32'(ovl_cfg), 32'h0);
    foreach (ROWS[i]) begin
      do_op(ROWS[i].op, ROWS[i].w);
      if (ROWS[i].op == OP_READ) chk("row read", 32'(r & ROWS[i].msk), 32'(ROWS[i].exp));
    end
    chk("hold released", 32'(hold), 32'h0);
    chk("pm word", 32'(pm[0]), 32'h00123456);
    core_wr(CTRL_OFFSET, 16'h0011);
    do_op(OP_READ, 16'h0000);
    chk("core latch", 32'(r), 32'h0000B2B2);
    do_op(OP_LATCH, 16'h8005);
    chk("overlay", 32'(ovl_cfg), 32'h00000005);
    chk("mem overlay", 32'(movl), 32'h00000005);
    do_op(OP_LATCH, OVL_OFFSET);
    do_op(OP_WRITE, 16'h4000);
    do_op(OP_WRITE, 16'h1111);
    chk("short read on", 32'(ovl_cfg[SHORT_READ_BIT]), 32'h1);
    chk("ctrl writes", 32'(ctl_hits), 32'h0);
    // short reads hand back the word fetched by the read before
    do_op(OP_LATCH, 16'h0010);
    do_op(OP_READ, 16'h0000);
    chk("short read 1", 32'(r), 32'h0000B2B2);
    do_op(OP_READ, 16'h0000);
    chk("short read 2", 32'(r), 32'h0000A1A1);
    core_wr(OVL_OFFSET, 16'h0000);
    @(posedge clk);
    chk("short read off", 32'(ovl_cfg[SHORT_READ_BIT]), 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped apb", q, 32'h0);
    // leave a nonzero overlay so that the reset below has work to do
    core_wr(OVL_OFFSET, 16'h4003);
    @(posedge clk);
    chk("core overlay", 32'(ovl_cfg), 32'h00004003);
    do_reset(3'h0);
    chk("no boot hold", 32'(hold), 32'h0);
    chk("overlay cleared", 32'(ovl_cfg), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
